// file: rtl/host_port_map.svh
// constants for the parallel host port: widths, pin straps and reset phase timing
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define DATA_W 8
`define ADDR_W 6
`define DED_ADDR_W 3

// length of the internal reset phase after a falling edge on the reset/power-down pin
`define CLK_MHZ 200
`define RESET_PHASE_NS 1000
`define RESET_PHASE_CYC (((`RESET_PHASE_NS * `CLK_MHZ) + 999) / 1000)
`define PHASE_CNT_W 16

// strap levels on the low address pins that select a multiplexed interface
`define STRAP_SEP_MUX 3'h3
`define STRAP_COM_MUX 3'h2

`endif

// file: rtl/host_port_pkg.sv
// types shared by the parallel host port modules
package host_port_pkg;

   typedef enum logic [2:0] {
      MODE_NONE = 3'h0,
      MODE_SEP_DED = 3'h1,
      MODE_SEP_MUX = 3'h2,
      MODE_COM_DED = 3'h3,
      MODE_COM_MUX = 3'h4,
      MODE_HANDSHAKE = 3'h5
   } host_mode_e;

   typedef enum logic [1:0] {
      DET_DOWN = 2'h0,
      DET_PHASE = 2'h1,
      DET_READY = 2'h3
   } detect_state_e;

   typedef enum logic [1:0] {
      ACC_IDLE = 2'h0,
      ACC_ACTIVE = 2'h1,
      ACC_HOLD = 2'h3
   } access_state_e;

   typedef struct packed {
      detect_state_e st;
      logic [15:0] cnt;
      host_mode_e mode;
      logic pd_prev;
   } detect_s;

   typedef struct packed {
      access_state_e st;
      logic is_read;
      logic [5:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic wr_pulse;
      logic rd_pulse;
      logic data_oe;
      logic wait_on;
      logic astrb_prev;
   } port_s;

endpackage

// file: rtl/host_mode_detect.sv
// reset/power-down sequencing and interface type detection
`timescale 1ns/1ps
`include "host_port_map.svh"

module host_mode_detect import host_port_pkg::*; #(
   parameter logic [15:0] PHASE_CYCLES = 16'(`RESET_PHASE_CYC)
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic reset_powerdown_in,
   input wire logic reg_addr_bit0,
   input wire logic reg_addr_bit1,
   input wire logic reg_addr_bit2,
   input wire logic addr_latch_pin,
   input wire logic write_strobe_n,
   input wire logic chip_select_n,
   output host_mode_e host_mode,
   output logic ready,
   output logic powerdown
);

   detect_s cur;
   detect_s next_cur;
   logic [2:0] strap;

   assign strap = {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};

   always_comb begin
      next_cur = cur;
      next_cur.pd_prev = reset_powerdown_in;
      if (reset_powerdown_in) begin
         next_cur.st = DET_DOWN;
         next_cur.mode = MODE_NONE;
      end else begin
         unique case (cur.st)
            DET_DOWN: begin
               if (cur.pd_prev) begin
                  next_cur.st = DET_PHASE;
                  next_cur.cnt = '0;
               end
            end
            DET_PHASE: begin
               next_cur.mode = MODE_NONE;
               next_cur.cnt = cur.cnt + 16'h0001;
               if (cur.cnt >= PHASE_CYCLES - 16'h0001) begin
                  next_cur.st = DET_READY;
                  // pin levels are read only once the phase is over
                  if (reg_addr_bit2 && reg_addr_bit1 && !chip_select_n) begin
                     next_cur.mode = MODE_HANDSHAKE;
                  end else if (addr_latch_pin) begin
                     // idle write strobe is high; a direction pin strapped low means common
                     next_cur.mode = write_strobe_n ? MODE_SEP_DED : MODE_COM_DED;
                  end else if (strap == `STRAP_SEP_MUX) begin
                     next_cur.mode = MODE_SEP_MUX;
                  end else if (strap == `STRAP_COM_MUX) begin
                     next_cur.mode = MODE_COM_MUX;
                  end else begin
                     next_cur.mode = MODE_SEP_DED;
                  end
               end
            end
            DET_READY: begin
            end
            default: next_cur.st = DET_DOWN;
         endcase
      end
   end

   // power-on behaves like a released hard reset: the phase runs first
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '{st: DET_PHASE, cnt: 16'h0000, mode: MODE_NONE, pd_prev: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign host_mode = cur.mode;
   assign ready = (cur.st == DET_READY);
   assign powerdown = (cur.st == DET_DOWN);

endmodule

// file: rtl/host_bus_port.sv
// parallel host bus port: strobe decoding, address latching, data transfer and wait handshake
`timescale 1ns/1ps
`include "host_port_map.svh"

// How it works
// - separate strobes: low read strobe makes the port drive addressed register data
// - common strobes: one low data strobe qualifies transfers, direction pin picks read/write
// - dedicated address: 8-bit data port driven on reads only, sampled on writes
// - multiplexed modes: the same eight lines carry address first, then data
// - separate-strobe multiplexed: address lines 0..5 latched while latch enable is high
// - common-strobe multiplexed: address lines 0..5 latched while address strobe is high
// - handshake mode: address lines 0..5 latched while the address strobe is low
// - handshake mode: wait low starts an access, high ends it; host waits
// - dedicated address: three address pins form register address bits 0, 1, 2
// - reset/power-down high: oscillator stopped, current sinks off, input pads isolated
// - falling edge on reset/power-down starts the internal reset sequence
// - shared pin roles follow the detected interface type
// - separate strobes: low write strobe stores the data byte in the addressed register
// - after reset the mode is cleared, then detected from control pin levels
// - wait stays released after reset until the first address strobe falling edge
module host_bus_port import host_port_pkg::*; #(
   parameter logic [15:0] PHASE_CYCLES = 16'(`RESET_PHASE_CYC)
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic reset_powerdown_in,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic addr_latch_pin,
   input wire logic reg_addr_bit0,
   output logic access_wait_n,
   output logic access_wait_oe,
   input wire logic reg_addr_bit1,
   input wire logic reg_addr_bit2,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata,
   output logic core_reset,
   output logic osc_enable,
   output logic current_sinks_on,
   output logic pads_isolated,
   output host_mode_e host_mode
);

   port_s cur;
   port_s next_cur;
   host_mode_e mode;
   logic ready;
   logic powerdown;
   logic strobe;
   logic dir_read;
   logic latch;
   logic muxed;
   logic dedicated;

   host_mode_detect #(
      .PHASE_CYCLES(PHASE_CYCLES)
   ) detect (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .reset_powerdown_in(reset_powerdown_in),
      .reg_addr_bit0(reg_addr_bit0),
      .reg_addr_bit1(reg_addr_bit1),
      .reg_addr_bit2(reg_addr_bit2),
      .addr_latch_pin(addr_latch_pin),
      .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n),
      .host_mode(mode),
      .ready(ready),
      .powerdown(powerdown)
   );

   // pin role decode per detected interface type
   always_comb begin
      strobe = 1'b0;
      dir_read = 1'b0;
      latch = 1'b0;
      muxed = 1'b0;
      dedicated = 1'b0;
      unique case (mode)
         MODE_SEP_DED, MODE_SEP_MUX: begin
            // pin 11 reads, pin 10 writes, both gated by chip select
            strobe = !chip_select_n && (!read_strobe_n || !write_strobe_n);
            dir_read = !read_strobe_n;
            muxed = (mode == MODE_SEP_MUX);
            dedicated = (mode == MODE_SEP_DED);
            latch = muxed && addr_latch_pin;
         end
         MODE_COM_DED, MODE_COM_MUX: begin
            // pin 11 is the data strobe, pin 10 the read/not-write select
            strobe = !chip_select_n && !read_strobe_n;
            dir_read = write_strobe_n;
            muxed = (mode == MODE_COM_MUX);
            dedicated = (mode == MODE_COM_DED);
            latch = muxed && addr_latch_pin;
         end
         MODE_HANDSHAKE: begin
            // chip select may inhibit the data strobe; tied low when unused
            strobe = !chip_select_n && !read_strobe_n;
            dir_read = write_strobe_n;
            muxed = 1'b1;
            latch = !addr_latch_pin;
         end
         MODE_NONE: begin
         end
         default: begin
         end
      endcase
   end

   always_comb begin
      next_cur = cur;
      next_cur.wr_pulse = 1'b0;
      next_cur.rd_pulse = 1'b0;
      next_cur.astrb_prev = addr_latch_pin;
      if (!ready) begin
         // covers power-down and the reset phase; wait goes back to released
         next_cur = '0;
         next_cur.astrb_prev = addr_latch_pin;
      end else begin
         // the wait output is claimed on the first falling address strobe
         if (mode == MODE_HANDSHAKE && cur.astrb_prev && !addr_latch_pin) begin
            next_cur.wait_on = 1'b1;
         end
         if (cur.st == ACC_IDLE) begin
            if (muxed && latch) begin
               // address phase on the shared lines; only six bits reach the latch
               next_cur.addr = host_data_in[5:0];
            end else if (dedicated) begin
               next_cur.addr = {3'h0, reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
            end
         end
         unique case (cur.st)
            ACC_IDLE: begin
               // a data strobe during an address phase is not an access
               if (strobe && !latch) begin
                  next_cur.st = ACC_ACTIVE;
                  next_cur.is_read = dir_read;
                  next_cur.rd_pulse = dir_read;
               end
            end
            ACC_ACTIVE: begin
               // register file answers combinationally from the held address
               if (cur.is_read) begin
                  next_cur.rdata = reg_rdata;
                  next_cur.data_oe = 1'b1;
               end else begin
                  next_cur.wdata = host_data_in;
               end
               next_cur.st = ACC_HOLD;
            end
            ACC_HOLD: begin
               // write data is taken up to the strobe release, where it is settled
               if (!cur.is_read && strobe) begin
                  next_cur.wdata = host_data_in;
               end
               if (!strobe) begin
                  next_cur.st = ACC_IDLE;
                  next_cur.data_oe = 1'b0;
                  next_cur.wr_pulse = !cur.is_read;
               end
            end
            default: next_cur.st = ACC_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // wait is low only in the first cycle of an access, high once data is settled
   assign access_wait_n = (cur.st != ACC_ACTIVE);
   assign access_wait_oe = cur.wait_on && (mode == MODE_HANDSHAKE);
   assign host_data_out = cur.rdata;
   assign host_data_oe = cur.data_oe;
   assign reg_addr = cur.addr;
   assign reg_wdata = cur.wdata;
   assign reg_write = cur.wr_pulse;
   assign reg_read = cur.rd_pulse;
   assign host_mode = mode;
   assign core_reset = !ready;
   // power-down gates the analog side; the pads stay isolated the whole time
   assign osc_enable = !powerdown;
   assign current_sinks_on = !powerdown;
   assign pads_isolated = powerdown;

endmodule

// file: verification/host_port_asserts.sv
// assertions on the host bus port pins
`timescale 1ns/1ps
module host_port_asserts import host_port_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic reset_powerdown_in,
   input wire logic chip_select_n,
   input wire logic addr_latch_pin,
   input wire logic access_wait_n,
   input wire logic access_wait_oe,
   input wire logic host_data_oe,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic core_reset,
   input wire logic osc_enable,
   input wire logic current_sinks_on,
   input wire logic pads_isolated,
   input wire host_mode_e host_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rd; !reg_read && host_data_oe ##1 host_data_oe; endsequence
   property p_rd; reg_read |=> s_rd; endproperty
   a_rd: assert property (p_rd) else $error("no read data");
   property p_oe; reg_write |-> !host_data_oe; endproperty
   a_oe: assert property (p_oe) else $error("bus driven");
   property p_cs; $past(chip_select_n) |-> !reg_read; endproperty
   a_cs: assert property (p_cs) else $error("unselected read");
   property p_pd; reset_powerdown_in [*2] |->
      pads_isolated && !osc_enable && !current_sinks_on; endproperty
   a_pd: assert property (p_pd) else $error("no power-down");
   property p_rst; $fell(reset_powerdown_in) |-> core_reset [*2]; endproperty
   a_rst: assert property (p_rst) else $error("no reset phase");
   property p_idle; core_reset |-> !reg_read && !reg_write && host_mode == MODE_NONE;
   endproperty
   a_idle: assert property (p_idle) else $error("active in reset");
   property p_hiz; host_mode != MODE_HANDSHAKE |-> !access_wait_oe; endproperty
   a_hiz: assert property (p_hiz) else $error("wait driven");
   // wait may only be claimed one edge after the address strobe was seen to fall
   property p_claim; $rose(access_wait_oe) |->
      !$past(addr_latch_pin) && $past(addr_latch_pin, 2); endproperty
   a_claim: assert property (p_claim) else $error("wait claimed early");
   property p_wt; $fell(access_wait_n) |=> access_wait_n; endproperty
   a_wt: assert property (p_wt) else $error("wait too long");
endmodule

bind host_bus_port host_port_asserts u_host_port_asserts (.ref_clk, .reset_n,
   .reset_powerdown_in, .chip_select_n, .addr_latch_pin, .access_wait_n, .access_wait_oe,
   .host_data_oe,
   .reg_write, .reg_read, .core_reset, .osc_enable, .current_sinks_on, .pads_isolated,
   .host_mode);

// file: verification/host_model.sv
// behavioural host driving the parallel bus pins
`timescale 1ns/1ps
module host_model import host_port_pkg::*; (
   input wire logic ref_clk,
   input wire logic access_wait_n,
   input wire logic [7:0] hbus,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic al,
   output logic [2:0] a,
   output logic [7:0] hd
);
   // accesses whose wait never came back high; the bench judges this count
   int stalls = 0;
   initial begin
      {al, wr_n, cs_n, a} = 6'h38;
      rd_n = 1'b1;
      hd = 8'h00;
   end
   task automatic strap(input logic [5:0] s);
      {al, wr_n, cs_n, a} = s;
   endtask
   task automatic xfer(input logic [2:0] m, input logic [5:0] ad, input logic wr,
      input logic [7:0] wd, output logic [7:0] rd);
      logic hs, mux, sep;
      int n;
      hs = m == MODE_HANDSHAKE;
      mux = hs || m inside {MODE_SEP_MUX, MODE_COM_MUX};
      sep = m inside {MODE_SEP_DED, MODE_SEP_MUX};
      if (mux) begin
         hd = {2'h3, ad};
         al = !hs;
         repeat (2) @(negedge ref_clk);
         al = hs;
      end else begin
         a = ad[2:0];
      end
      @(negedge ref_clk);
      hd = wr ? wd : ~wd;
      cs_n = 1'b0;
      wr_n = !wr;
      rd_n = wr && sep;
      n = 0;
      repeat (4) @(negedge ref_clk);
      while (access_wait_n !== 1'b1 && n < 16) begin
         @(negedge ref_clk);
         n++;
      end
      if (access_wait_n !== 1'b1) stalls++;
      rd = hbus;
      rd_n = 1'b1;
      if (sep) wr_n = 1'b1;
      @(negedge ref_clk);
      // data held one cycle past the strobe, since writes commit at its end
      hd = ~hd;
      cs_n = !hs;
      repeat (2) @(negedge ref_clk);
   endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the parallel host bus port
`timescale 1ns/1ps
module tb;
   import host_port_pkg::*;
   // short reset phase keeps each mode boot to a few cycles
   localparam logic [15:0] PHASE = 16'h0004;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic pd = 1'b0;
   logic cs_n, rd_n, wr_n, al, wait_n, wait_oe, oe, reg_write, reg_read;
   logic core_reset, osc, sinks, iso;
   logic [2:0] a;
   logic [5:0] reg_addr, wr_addr;
   logic [7:0] hd, hbus, dout, wdata, wr_data, regs [64];
   host_mode_e host_mode;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   int wr_seen = 0;
   int rd_seen = 0;
   int wait_lows = 0;
   always #2.5 ref_clk = ~ref_clk;
   assign hbus = oe ? dout : hd;
   host_bus_port #(.PHASE_CYCLES(PHASE)) u_host_bus_port (.ref_clk, .reset_n,
      .reset_powerdown_in(pd), .chip_select_n(cs_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .addr_latch_pin(al), .reg_addr_bit0(wait_oe ? wait_n : a[0]),
      .access_wait_n(wait_n), .access_wait_oe(wait_oe), .reg_addr_bit1(a[1]),
      .reg_addr_bit2(a[2]), .host_data_in(hbus), .host_data_out(dout),
      .host_data_oe(oe), .reg_addr, .reg_wdata(wdata), .reg_write, .reg_read,
      .reg_rdata(regs[reg_addr]), .core_reset, .osc_enable(osc),
      .current_sinks_on(sinks), .pads_isolated(iso), .host_mode);
   host_model u_host_model (.ref_clk, .access_wait_n(wait_n), .hbus, .cs_n, .rd_n,
      .wr_n, .al, .a, .hd);
   always @(posedge ref_clk) begin
      cycles++;
      if (reg_write === 1'b1) begin
         regs[reg_addr] <= wdata;
         wr_addr <= reg_addr;
         wr_data <= wdata;
         wr_seen++;
      end
      if (wait_oe === 1'b1 && wait_n === 1'b0) wait_lows++;
      if (reg_read === 1'b1) rd_seen++;
      if (cycles == 3000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic boot(input logic [5:0] s, input logic [2:0] m);
      u_host_model.strap(s);
      pd = 1'b1;
      repeat (3) @(negedge ref_clk);
      check8({2'h0, osc, sinks, iso, host_mode}, 8'h08);
      pd = 1'b0;
      repeat (2) @(negedge ref_clk);
      check8({7'h0, core_reset}, 8'h01);
      repeat (PHASE + 4) @(negedge ref_clk);
      check8({5'h0, host_mode}, {5'h0, m});
   endtask
   task automatic rw(input logic [2:0] m, input logic [5:0] ad, input logic [7:0] d);
      logic [7:0] r;
      int w;
      int rc;
      w = wr_seen;
      rc = rd_seen;
      u_host_model.xfer(m, ad, 1'b1, d, r);
      check8(8'(wr_seen - w), 8'h01);
      check8({2'h0, wr_addr}, {2'h0, ad});
      check8(wr_data, d);
      u_host_model.xfer(m, ad, 1'b0, 8'h00, r);
      check8(r, d);
      check8(8'(wr_seen - w), 8'h01);
      check8(8'(rd_seen - rc), 8'h01);
      check8({7'h0, oe}, 8'h00);
      check8(8'(u_host_model.stalls), 8'h00);
   endtask
   task automatic t_sep_ded;
      boot(6'h38, MODE_SEP_DED);
      rw(MODE_SEP_DED, 6'h05, 8'h3c);
      $display("end sep_ded");
   endtask
   task automatic t_cs_off;
      int w;
      w = wr_seen;
      u_host_model.wr_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      u_host_model.wr_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      check8(8'(wr_seen - w), 8'h00);
      $display("end cs_off");
   endtask
   task automatic t_com_ded;
      logic [7:0] r;
      boot(6'h28, MODE_COM_DED);
      rw(MODE_COM_DED, 6'h06, 8'h81);
      u_host_model.xfer(MODE_COM_DED, 6'h03, 1'b0, 8'h00, r);
      check8(r, 8'ha6);
      $display("end com_ded");
   endtask
   task automatic t_hs;
      int w;
      boot(6'h36, MODE_HANDSHAKE);
      check8({7'h0, wait_oe}, 8'h00);
      w = wait_lows;
      rw(MODE_HANDSHAKE, 6'h2a, 8'h5b);
      check8({7'h0, wait_oe}, 8'h01);
      check8(8'(wait_lows - w), 8'h02);
      $display("end handshake");
   endtask
   task automatic t_mux;
      boot(6'h1b, MODE_SEP_MUX);
      rw(MODE_SEP_MUX, 6'h3e, 8'h69);
      boot(6'h1a, MODE_COM_MUX);
      rw(MODE_COM_MUX, 6'h11, 8'hc7);
      $display("end mux");
   endtask
   initial begin
      for (int i = 0; i < 64; i++) regs[i] = 8'(i) ^ 8'ha5;
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (PHASE + 4) @(negedge ref_clk);
      t_sep_ded();
      t_cs_off();
      t_com_ded();
      t_hs();
      t_mux();
      close_out();
   end
endmodule
